/* File: hdl/cls_regs.vh */
`ifndef CLS_REGS_VH
`define CLS_REGS_VH
// Register byte offsets
`define CLS_CTRL_OFS     12'h000
`define CLS_FAST_OFS     12'h004
`define CLS_PRE_OFS      12'h008
`define CLS_INPUT_CURRENT_LIMIT_OFS     12'h00C
`define CLS_FLAG_OFS     12'h010
`define CLS_STAT_OFS     12'h014
`define CLS_RES_OFS      12'h020
`define CLS_RES_LAST     12'h038
// Control fields
`define CLS_CTRL_LP      0
`define CLS_CTRL_RATE_LO 1
`define CLS_CTRL_RATE_HI 2
`define CLS_CTRL_TRIG    3
// Fast charge fields
`define CLS_FAST_STEP    8
// Precharge register cold select field
`define CLS_PRE_COLD_LO  8
`define CLS_PRE_COLD_HI  9
// Flag bits
`define CLS_FLG_DONE     0
`define CLS_FLG_HIT      1
`define CLS_FLG_OPEN     2
// Reset values
`define CLS_CTRL_RST     4'h0
`define CLS_FAST_RST     8'h08
`define CLS_PRE_RST      8'h02
`define CLS_INPUT_CURRENT_LIMIT_RST     8'h00
`define CLS_MAX_RST      8'hFF
// Converter channels
`define CLS_CH_VIN       3'h0
`define CLS_CH_RAIL      3'h1
`define CLS_CH_IIN       3'h2
`define CLS_CH_VBAT      3'h3
`define CLS_CH_TS        3'h4
`define CLS_CH_AIN       3'h5
`define CLS_CH_ICHG      3'h6
`define CLS_CH_LIMIT     3'h7
// Limit pin open level: 14 kohm at 80 uA over 1.2 V full scale
`define CLS_OPEN_CODE    16'hEEEE
// Limit code shift: 2 * 256 / 65536 = 1/128
`define CLS_LIM_SHIFT    7
// Timing
`define CLS_CLK_MHZ      100
`define CLS_INT_US       128
`define CLS_ROUND_MS     225
`define CLS_PER1_MS      1000
`define CLS_PER2_MS      10000
`define CLS_PER3_MS      20000
`endif

/* File: hdl/cls_seq.v */
// Operation
// - Measure limit pin after power-on reset
// - Clamp fast code, set limit-hit flag
// - Clamp precharge code without flag
// - Maximum code is twice R times bias
// - Clamp ignores charge step select bit
// - Open pin: retry once, then disable
// - Limit measurement only after power-on
// - Battery mode converts at selected period
// - Battery conversion done sets flag, interrupt
// - Low-power bit clear keeps converter off without input power
// - Input power: continuous round-robin conversion
// - No done interrupt with input power
// - Results readable at any time
// - Voltages 16-bit, 6 V full scale
// - Input current scale follows current limit
// - Thermistor, analog input 1.2 V scale
// - Charge current percent of selected reference
// - 12 effective bits in 16-bit codes
// - Interrupt is 128 us low pulse
// - Flags clear when read
`timescale 1ns/1ps
`include "cls_regs.vh"
module cls_seq #(
  parameter INT_CYCLES = `CLS_INT_US * `CLS_CLK_MHZ,
  parameter RR_CYCLES  = `CLS_ROUND_MS * 1000 * `CLS_CLK_MHZ / 7,
  parameter PER1       = `CLS_PER1_MS * 1000 * `CLS_CLK_MHZ,
  parameter PER2       = `CLS_PER2_MS * 1000 * `CLS_CLK_MHZ,
  parameter PER3       = `CLS_PER3_MS * 1000 * `CLS_CLK_MHZ,
  parameter [7:0] INPUT_CURRENT_LIMIT_LOW_MAX = 8'h0F
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        vin_present,
  input  wire        vin_valid,
  input  wire        precharge_active,
  input  wire        cold_region,
  output reg         conv_start,
  output reg  [2:0]  conv_chan,
  input  wire        conv_done,
  input  wire [11:0] conv_data,
  output reg         limit_bias_en,
  output reg         charge_disable,
  output reg  [7:0]  fast_charge_code,
  output reg         charge_step_select,
  output reg  [7:0]  ichg_ref_code,
  output reg         int_n
);
  localparam S_LIM  = 2'h0;
  localparam S_IDLE = 2'h1;
  localparam S_WAIT = 2'h2;
  localparam [15:0] OPEN_FULL = `CLS_OPEN_CODE;

  // Open limit pin test, used by sequencer and flags
  function is_open;
    input [11:0] d;
    begin
      is_open = (d >= OPEN_FULL[15:4]);
    end
  endfunction

  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] m;
    begin
      clamp8 = (v > m) ? m : v;
    end
  endfunction

  // Pin synchronisers
  reg  [3:0]  sync1_q;
  reg  [3:0]  sync2_q;
  wire        vin_s  = sync2_q[0];
  wire        inok_s = sync2_q[1];
  wire        pre_s  = sync2_q[2];
  wire        cold_s = sync2_q[3];

  reg  [1:0]  state_q;
  reg         retry_q;
  reg         sweep_q;
  reg  [7:0]  max_q;
  reg         lp_q;
  reg  [1:0]  rate_q;
  reg         trig_q;
  reg  [7:0]  pre_q;
  reg  [1:0]  coldsel_q;
  reg  [7:0]  input_current_limit_q;
  reg  [2:0]  flag_q;
  reg  [2:0]  rr_chan_q;
  reg  [31:0] tmr_q;
  reg  [15:0] int_cnt_q;
  reg  [15:0] res_q [0:6];
  reg         wr_q;
  reg  [11:0] wa_q;

  wire        acc   = hsel & hready & htrans[1];
  wire        rd    = acc & ~hwrite;
  wire        rdflg = rd & (haddr == `CLS_FLAG_OFS);
  reg  [15:0] scaled;
  reg  [31:0] per;
  reg  [2:0]  flag_set;
  reg         fire_int;
  integer     i;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge clk) begin
    if (reset) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {cold_region, precharge_active, vin_valid, vin_present};
      sync2_q <= sync1_q;
    end
  end

  // Result scaling
  always @* begin
    scaled = {conv_data, 4'h0};
    if (conv_chan == `CLS_CH_IIN) begin
      if (!inok_s)
        scaled = 16'h0000;
      else if (input_current_limit_q <= INPUT_CURRENT_LIMIT_LOW_MAX)
        scaled = conv_data[11] ? 16'hFFFF
                 : {conv_data[10:0], 5'h00};
    end
  end

  always @* begin
    case (rate_q)
      2'h1:    per = PER1;
      2'h2:    per = PER2;
      default: per = PER3;
    endcase
  end

  // Charge current reference selection
  always @* begin
    if (pre_s)
      ichg_ref_code = pre_q;
    else if (cold_s)
      ichg_ref_code = {6'h00, coldsel_q};
    else
      ichg_ref_code = fast_charge_code;
  end

  // Sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_q        <= S_LIM;
      retry_q        <= 1'b0;
      sweep_q        <= 1'b0;
      max_q          <= `CLS_MAX_RST;
      charge_disable <= 1'b0;
      conv_start     <= 1'b1;
      conv_chan      <= `CLS_CH_LIMIT;
      limit_bias_en  <= 1'b1;
      rr_chan_q      <= 3'h0;
      tmr_q          <= 32'h0;
      for (i = 0; i < 7; i = i + 1)
        res_q[i] <= 16'h0000;
    end else begin
      conv_start <= 1'b0;
      case (state_q)
        S_LIM: begin
          if (conv_done) begin
            if (is_open(conv_data)) begin
              if (!retry_q) begin
                retry_q    <= 1'b1;
                conv_start <= 1'b1;
              end else begin
                charge_disable <= 1'b1;
                limit_bias_en  <= 1'b0;
                state_q        <= S_IDLE;
              end
            end else begin
              max_q <= ({conv_data, 4'h0} >> `CLS_LIM_SHIFT) > 16'h00FF
                       ? 8'hFF
                       : conv_data[10:3];
              limit_bias_en <= 1'b0;
              state_q       <= S_IDLE;
            end
          end
        end
        S_IDLE: begin
          tmr_q <= tmr_q + 32'h1;
          if (vin_s) begin
            sweep_q <= 1'b0;
            if (tmr_q >= RR_CYCLES - 1) begin
              tmr_q      <= 32'h0;
              conv_start <= 1'b1;
              conv_chan  <= rr_chan_q;
              rr_chan_q  <= (rr_chan_q == `CLS_CH_ICHG) ? 3'h0
                            : rr_chan_q + 3'h1;
              state_q    <= S_WAIT;
            end
          end else if (!lp_q) begin
            tmr_q <= 32'h0;
          end else if (trig_q ||
                       (rate_q != 2'h0 && tmr_q >= per - 1)) begin
            tmr_q      <= 32'h0;
            sweep_q    <= 1'b1;
            conv_start <= 1'b1;
            conv_chan  <= `CLS_CH_VIN;
            state_q    <= S_WAIT;
          end
        end
        default: begin
          if (!sweep_q)
            tmr_q <= tmr_q + 32'h1;
          if (conv_done) begin
            res_q[conv_chan] <= scaled;
            if (sweep_q && conv_chan != `CLS_CH_ICHG) begin
              conv_start <= 1'b1;
              conv_chan  <= conv_chan + 3'h1;
            end else begin
              sweep_q <= 1'b0;
              state_q <= S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Flag sources
  always @* begin
    flag_set = 3'h0;
    fire_int = 1'b0;
    if (state_q == S_WAIT && conv_done && sweep_q &&
        conv_chan == `CLS_CH_ICHG && !vin_s) begin
      flag_set[`CLS_FLG_DONE] = 1'b1;
      fire_int = 1'b1;
    end
    if (state_q == S_LIM && conv_done && retry_q &&
        is_open(conv_data)) begin
      flag_set[`CLS_FLG_OPEN] = 1'b1;
      fire_int = 1'b1;
    end
    if (wr_q && wa_q == `CLS_FAST_OFS && hwdata[7:0] > max_q)
      flag_set[`CLS_FLG_HIT] = 1'b1;
  end

  // Register file
  always @(posedge clk) begin
    if (reset) begin
      wr_q               <= 1'b0;
      wa_q               <= 12'h000;
      lp_q               <= 1'b0;
      rate_q             <= 2'h0;
      trig_q             <= 1'b0;
      fast_charge_code   <= `CLS_FAST_RST;
      charge_step_select <= 1'b0;
      pre_q              <= `CLS_PRE_RST;
      coldsel_q          <= 2'h0;
      input_current_limit_q             <= `CLS_INPUT_CURRENT_LIMIT_RST;
      flag_q             <= 3'h0;
      hrdata             <= 32'h0;
    end else begin
      wr_q <= acc & hwrite;
      wa_q <= haddr;
      if (state_q == S_IDLE && lp_q && !vin_s && trig_q)
        trig_q <= 1'b0;
      flag_q <= (flag_q & ~(rdflg ? 3'h7 : 3'h0)) | flag_set;
      if (wr_q) begin
        if (wa_q == `CLS_CTRL_OFS) begin
          lp_q   <= hwdata[`CLS_CTRL_LP];
          rate_q <= hwdata[`CLS_CTRL_RATE_HI:`CLS_CTRL_RATE_LO];
          if (hwdata[`CLS_CTRL_TRIG])
            trig_q <= 1'b1;
        end else if (wa_q == `CLS_FAST_OFS) begin
          fast_charge_code   <= clamp8(hwdata[7:0], max_q);
          charge_step_select <= hwdata[`CLS_FAST_STEP];
        end else if (wa_q == `CLS_PRE_OFS) begin
          pre_q     <= clamp8(hwdata[7:0], max_q);
          coldsel_q <= hwdata[`CLS_PRE_COLD_HI:`CLS_PRE_COLD_LO];
        end else if (wa_q == `CLS_INPUT_CURRENT_LIMIT_OFS) begin
          input_current_limit_q <= hwdata[7:0];
        end
      end
      if (rd) begin
        if (haddr == `CLS_CTRL_OFS)
          hrdata <= {28'h0, trig_q, rate_q, lp_q};
        else if (haddr == `CLS_FAST_OFS)
          hrdata <= {23'h0, charge_step_select, fast_charge_code};
        else if (haddr == `CLS_PRE_OFS)
          hrdata <= {22'h0, coldsel_q, pre_q};
        else if (haddr == `CLS_INPUT_CURRENT_LIMIT_OFS)
          hrdata <= {24'h0, input_current_limit_q};
        else if (haddr == `CLS_FLAG_OFS)
          hrdata <= {29'h0, flag_q};
        else if (haddr == `CLS_STAT_OFS)
          hrdata <= {20'h0, vin_s, charge_disable,
                     (state_q == S_LIM), state_q == S_WAIT, max_q};
        else if (haddr >= `CLS_RES_OFS && haddr <= `CLS_RES_LAST &&
                 haddr[1:0] == 2'h0)
          hrdata <= {16'h0, res_q[haddr[4:2] - 3'h0]};
        else
          hrdata <= 32'h0;
      end
    end
  end

  // Interrupt pulse
  always @(posedge clk) begin
    if (reset) begin
      int_cnt_q <= 16'h0;
      int_n     <= 1'b1;
    end else if (fire_int && int_n) begin
      int_cnt_q <= INT_CYCLES[15:0] - 16'h1;
      int_n     <= 1'b0;
    end else if (!int_n) begin
      if (int_cnt_q == 16'h0)
        int_n <= 1'b1;
      else
        int_cnt_q <= int_cnt_q - 16'h1;
    end
  end
endmodule // cls_seq

/* File: testbench/cls_seq_asserts.sv */
`timescale 1ns/1ps
module cls_seq_chk #(
  parameter INT_CYCLES = 12800
) (
  input wire        clk,
  input wire        reset,
  input wire        hreadyout,
  input wire        hresp,
  input wire        vin_present,
  input wire        conv_start,
  input wire [2:0]  conv_chan,
  input wire        conv_done,
  input wire [11:0] conv_data,
  input wire        limit_bias_en,
  input wire        charge_disable,
  input wire        int_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  reg [15:0] lo_q;
  reg [1:0]  n7_q;
  always @(posedge clk) begin
    lo_q <= (reset || int_n) ? 16'h0 : lo_q + 16'h1;
    if (reset)
      n7_q <= 2'h0;
    else if (conv_done && conv_chan == 3'h7 && n7_q != 2'h3)
      n7_q <= n7_q + 2'h1;
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero wait");
  chk_limit_first: assert property ($fell(reset) |-> ##[0:1]
    (conv_start && conv_chan == 3'h7)) else $error("no limit conversion");
  chk_bias_only: assert property (conv_start && conv_chan != 3'h7
    |-> !limit_bias_en) else $error("bias on in normal conversion");
  chk_int_width: assert property ($rose(int_n) |-> lo_q == INT_CYCLES)
    else $error("interrupt pulse width wrong");
  chk_open_retry: assert property ($rose(charge_disable) |-> n7_q == 2'h2)
    else $error("disable without two limit conversions");
  chk_disable_sticky: assert property (charge_disable |=> charge_disable)
    else $error("charge disable released");
  chk_done_int: assert property (conv_done && conv_chan == 3'h6 && int_n &&
    !vin_present && $past(!vin_present, 3) |-> ##[1:3] !int_n)
    else $error("no interrupt after sweep");
  chk_no_int_vin: assert property (conv_done && conv_chan != 3'h7 &&
    vin_present && $past(vin_present, 3) |=> !$fell(int_n) [*2])
    else $error("interrupt with input power");
  chk_chan_steady: assert property ($changed(conv_chan) |-> conv_start)
    else $error("channel changed mid conversion");
  cover property ($fell(int_n));
  cover property (conv_done && conv_chan == 3'h6);
  cover property ($rose(charge_disable));
endmodule // cls_seq_chk

bind cls_seq cls_seq_chk #(.INT_CYCLES(INT_CYCLES)) u_chk (.clk, .reset,
  .hreadyout, .hresp, .vin_present, .conv_start, .conv_chan, .conv_done,
  .conv_data, .limit_bias_en, .charge_disable, .int_n);

/* File: testbench/cls_adc_model.sv */
`timescale 1ns/1ps
module cls_adc_model (
  input  wire        clk,
  input  wire        conv_start,
  input  wire [2:0]  conv_chan,
  input  wire [11:0] limit_code,
  input  wire        slow,
  output reg         conv_done,
  output reg  [11:0] conv_data
);
  integer   n = -1;
  reg [2:0] ch = 3'h0;
  initial begin
    conv_done = 1'b0;
    conv_data = 12'h000;
  end
  // Data toggles outside the done cycle
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (conv_start) begin
      n  <= slow ? 6 : 2;
      ch <= conv_chan;
    end else if (n > 0)
      n <= n - 1;
    if (n == 1 && !conv_start) begin
      conv_done <= 1'b1;
      conv_data <= (ch == 3'h7) ? limit_code : {1'b0, ch, 8'h5A};
    end
  end
endmodule // cls_adc_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "cls_regs.vh"
module testbench;
  reg         clk = 1'b0, reset = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  reg  [11:0] haddr = 12'h000, limit_code = 12'h300;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0, q, e;
  reg         vin_present = 1'b0, vin_valid = 1'b0, slow = 1'b0;
  reg         precharge_active = 1'b0, cold_region = 1'b0, int_q = 1'b1;
  wire        hready, hreadyout, hresp, conv_start, conv_done, int_n;
  wire        limit_bias_en, charge_disable, charge_step_select;
  wire [31:0] hrdata;
  wire [2:0]  conv_chan;
  wire [11:0] conv_data;
  wire [7:0]  fast_charge_code, ichg_ref_code;
  integer     n_fail = 0, checked = 0, n_st = 0, n_lim = 0, n_int = 0;
  integer     s, ni, i;
  assign hready = hreadyout;
  cls_seq #(.INT_CYCLES(16), .RR_CYCLES(20), .PER1(50), .PER2(100),
    .PER3(200)) i_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .vin_present,
    .vin_valid, .precharge_active, .cold_region, .conv_start, .conv_chan,
    .conv_done, .conv_data, .limit_bias_en, .charge_disable,
    .fast_charge_code, .charge_step_select, .ichg_ref_code, .int_n);
  cls_adc_model i_adc (.clk, .conv_start, .conv_chan, .limit_code, .slow,
    .conv_done, .conv_data);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    int_q <= int_n;
    if (int_q && !int_n) n_int <= n_int + 1;
    if (conv_start) n_st <= n_st + 1;
    if (reset) n_lim <= 0;
    else if (conv_start && conv_chan == 3'h7) n_lim <= n_lim + 1;
  end
  task wrap_up;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input [11:0] a, input w, input [31:0] d);
    integer k;
    begin
      k = 0;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hready !== 1'b1 && k < 50) begin @(posedge clk); k = k + 1; end
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1 && k < 50) begin @(posedge clk); k = k + 1; end
      q = hrdata;
      if (k >= 50) begin n_fail = n_fail + 1; wrap_up; end
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] x);
    begin xfer(a, 1'b0, 32'h0); chk(q & m, x); end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task wait_low(input integer sel);
    integer k;
    begin
      k = 0;
      while ((sel ? limit_bias_en : int_n) !== 1'b0 && k < 2000) begin
        @(posedge clk); k = k + 1;
      end
      if (k >= 2000) begin n_fail = n_fail + 1; wrap_up; end
    end
  endtask
  task do_reset;
    begin
      reset <= 1'b1;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
    end
  endtask
  initial begin
    do_reset;
    wait_low(1);
    repeat (4) @(posedge clk);
    chk(n_lim, 1);
    rd(`CLS_STAT_OFS, 32'hFF, 32'h60);
    wr(`CLS_FAST_OFS, 32'h1FF);
    rd(`CLS_FAST_OFS, 32'h1FF, 32'h160);
    chk({charge_step_select, fast_charge_code}, 32'h160);
    rd(`CLS_FLAG_OFS, 32'h2, 32'h2);
    rd(`CLS_FLAG_OFS, 32'h2, 32'h0);
    wr(`CLS_PRE_OFS, 32'hFF);
    rd(`CLS_PRE_OFS, 32'hFF, 32'h60);
    rd(`CLS_FLAG_OFS, 32'h2, 32'h0);
    precharge_active <= 1'b1;
    repeat (4) @(posedge clk);
    chk(ichg_ref_code, 32'h60);
    precharge_active <= 1'b0;
    cold_region <= 1'b1;
    wr(`CLS_PRE_OFS, 32'h200);
    repeat (4) @(posedge clk);
    chk(ichg_ref_code, 32'h2);
    cold_region <= 1'b0;
    repeat (4) @(posedge clk);
    chk(ichg_ref_code, 32'h60);
    $display("Limit test done");
    slow <= 1'b1;
    s = n_st;
    wr(`CLS_CTRL_OFS, 32'h8);
    repeat (40) @(posedge clk);
    chk(n_st - s, 0);
    rd(`CLS_CTRL_OFS, 32'h8, 32'h8);
    wr(`CLS_CTRL_OFS, 32'h9);
    wait_low(0);
    rd(`CLS_FLAG_OFS, 32'h1, 32'h1);
    rd(`CLS_CTRL_OFS, 32'h8, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      e = (i == 2) ? 32'h0 : {17'h0, i[2:0], 8'h5A, 4'h0};
      rd(12'(`CLS_RES_OFS + 4 * i), 32'hFFFFFFFF, e);
    end
    $display("Manual sweep test done");
    slow <= 1'b0;
    wr(`CLS_CTRL_OFS, 32'h3);
    s = n_st;
    repeat (500) @(posedge clk);
    chk((n_st - s) >= 35 && (n_st - s) <= 77, 1);
    wr(`CLS_CTRL_OFS, 32'h1);
    repeat (60) @(posedge clk);
    s = n_st;
    repeat (300) @(posedge clk);
    chk(n_st - s, 0);
    $display("Period test done");
    vin_present <= 1'b1;
    vin_valid <= 1'b1;
    repeat (40) @(posedge clk);
    s = n_st;
    ni = n_int;
    repeat (700) @(posedge clk);
    chk((n_st - s) >= 33 && (n_st - s) <= 36, 1);
    chk(n_int - ni, 0);
    rd(`CLS_RES_OFS, 32'hFFFFFFFF, 32'h5A0);
    rd(`CLS_RES_OFS + 12'h008, 32'hFFFFFFFF, 32'h4B40);
    wr(`CLS_INPUT_CURRENT_LIMIT_OFS, 32'h20);
    repeat (200) @(posedge clk);
    rd(`CLS_RES_OFS + 12'h008, 32'hFFFFFFFF, 32'h25A0);
    $display("Input power test done");
    vin_present <= 1'b0;
    vin_valid <= 1'b0;
    limit_code <= 12'hF00;
    do_reset;
    wait_low(1);
    repeat (4) @(posedge clk);
    chk(charge_disable, 1);
    chk(n_lim, 2);
    rd(`CLS_FLAG_OFS, 32'h4, 32'h4);
    wr(`CLS_CTRL_OFS, 32'h9);
    repeat (80) @(posedge clk);
    chk(n_lim, 2);
    chk(charge_disable, 1);
    $display("Open pin test done");
    wrap_up;
  end
endmodule // testbench
